// ---- design/mfd_top.sv ----
// Meter function decoder: mode and range to analog switch controls
module mfd_top
    import mfd_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic [3:0] i_mode,
    input wire logic [3:0] i_range,
    input wire logic i_timebase_divide,
    input wire logic [1:0] i_ohm_source_select,
    input wire logic i_charge_toggle,
    input wire logic i_charge_set_select,
    output logic o_diode_test_flag,
    output logic o_source_enable_flag,
    output logic o_short_test_flag,
    output logic o_charge_timing_mode,
    output logic o_direct_output_enable,
    output logic [2:0] o_sw_1k_field,
    output logic [2:0] o_sw_10k_field,
    output logic [2:0] o_sw_100k_field,
    output logic [2:0] o_sw_1m_field,
    output logic [1:0] o_sw_10m_field,
    output logic o_path_10m_e,
    output logic o_path_10m_f,
    output mfd_pkg::mfd_ref_t o_ref_set,
    output mfd_pkg::mfd_src_t o_ohm_source_out,
    output logic o_charge_level_high,
    output logic o_cmp_pair_second,
    output logic [3:0] o_mode_seen
);
    import mfd_pkg::*;

    mfd_state_t state_q;
    mfd_state_t state_d;
    mfd_if flags();
    logic [2:0] ladder [4];
    logic e_sig;

    // Snapshot of the last programmed fields for host readback only;
    // the decode itself takes the fields with no added latency
    always_comb begin
        state_d = state_q;
        if (i_clk_en) begin
            state_d.mode = i_mode;
            state_d.range = i_range;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= '{mode: MODE_RESET, range: RANGE_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    assign o_mode_seen = state_q.mode;

    mfd_mode_dec u_mode_dec (
        .i_mode(i_mode),
        .o_flags(flags)
    );

    assign o_diode_test_flag = flags.diode_test_flag;
    assign o_source_enable_flag = flags.source_enable_flag;
    assign o_short_test_flag = flags.short_test_flag;
    assign o_charge_timing_mode = flags.charge_timing_mode;
    assign o_direct_output_enable = flags.direct_output_enable;

    assign e_sig = |i_range;
    assign o_path_10m_e = e_sig;
    assign o_path_10m_f = ~e_sig;

    // Range bit a (msb) drives the 1k field, down to d on the 1M field
    for (genvar g = 0; g < 4; g++) begin : g_ladder
        always_comb begin
            if (i_mode[3:2] == MODE_DIV_PFX) begin
                ladder[g] = {1'b0, {2{i_range[3-g]}}};
            end else if (i_mode[3:2] == MODE_LADDER_PFX) begin
                ladder[g] = {3{i_range[3-g]}};
            end else begin
                ladder[g] = 3'h0;
            end
        end
    end

    assign o_sw_1k_field = ladder[0];
    assign o_sw_10k_field = ladder[1];
    assign o_sw_100k_field = ladder[2];
    assign o_sw_1m_field = ladder[3];

    always_comb begin
        if (i_mode[3:2] == MODE_DIV_PFX) begin
            o_sw_10m_field = {1'b0, e_sig};
        end else if (i_mode[3:2] == MODE_LADDER_PFX) begin
            if (i_mode[MODE_PARALLEL_BIT]) begin
                o_sw_10m_field = {~e_sig, ~e_sig};
            end else begin
                o_sw_10m_field = {~e_sig, 1'b1};
            end
        end else begin
            o_sw_10m_field = 2'h0;
        end
    end

    always_comb begin
        if (!flags.source_enable_flag) begin
            o_ref_set = MFD_REF_OFF;
        end else if (i_timebase_divide) begin
            o_ref_set = MFD_REF_HIGH;
        end else begin
            o_ref_set = MFD_REF_LOW;
        end
    end

    // Charge level tracks the active reference set in capacitance mode
    assign o_charge_level_high = flags.charge_timing_mode
        & i_timebase_divide;
    assign o_cmp_pair_second = flags.charge_timing_mode
        & i_charge_set_select;

    always_comb begin
        if (flags.charge_timing_mode) begin
            o_ohm_source_out = i_charge_toggle ? MFD_SRC_AGND
                : MFD_SRC_REF;
        end else begin
            case (i_ohm_source_select)
                2'h0: o_ohm_source_out = MFD_SRC_HIZ;
                2'h1: o_ohm_source_out = MFD_SRC_AUX5;
                2'h2: o_ohm_source_out = MFD_SRC_REF;
                2'h3: o_ohm_source_out = MFD_SRC_VDD;
                default: o_ohm_source_out = MFD_SRC_HIZ;
            endcase
        end
    end

    a_unlisted_clear: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode == 4'h2 || i_mode[3:2] == 2'h1 || i_mode[3:2] == 2'h3)
        |-> !(o_diode_test_flag | o_source_enable_flag | o_short_test_flag
        | o_charge_timing_mode | o_direct_output_enable))
        else $error("unlisted mode left a flag set");
    a_ohm_flags: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode[3:1] == 3'h4) |-> (o_short_test_flag && o_source_enable_flag
        && !o_charge_timing_mode))
        else $error("resistor mode flags wrong");
    a_ladder_div: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode[3:2] == 2'h0) |-> (o_sw_1k_field == {1'b0, {2{i_range[3]}}}
        && o_sw_1m_field == {1'b0, {2{i_range[0]}}}))
        else $error("divider ladder field wrong");
    a_tenm_split: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        o_path_10m_e == (i_range != 4'h0) && o_path_10m_f != o_path_10m_e)
        else $error("ten meg path wrong");
    a_ladder_ref: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode[3:2] == 2'h2 && !i_mode[0]) |-> (o_sw_10m_field[0]
        && o_sw_10k_field == {3{i_range[2]}}))
        else $error("reference ladder field wrong");
    a_ref_off: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (o_ref_set == MFD_REF_OFF) == !o_source_enable_flag)
        else $error("reference gating wrong");
    a_ohm_select: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (!o_charge_timing_mode && i_ohm_source_select == 2'h1)
        |-> o_ohm_source_out == MFD_SRC_AUX5)
        else $error("ohm select wrong");
    a_charge_src: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        o_charge_timing_mode |-> o_ohm_source_out
        == (i_charge_toggle ? MFD_SRC_AGND : MFD_SRC_REF))
        else $error("charge source wrong");
    a_charge_pair: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        o_cmp_pair_second |-> (i_charge_set_select && i_mode[3:1] == 3'h5))
        else $error("comparator pair wrong");
    a_dc_clear: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode == 4'h0) |-> !(o_diode_test_flag | o_source_enable_flag
        | o_short_test_flag | o_charge_timing_mode | o_direct_output_enable))
        else $error("dc mode left a flag set");
    a_diode_only: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode == 4'h1) |-> (o_diode_test_flag && !o_source_enable_flag
        && !o_direct_output_enable && !o_short_test_flag))
        else $error("diode mode flags wrong");
    a_wideband_flags: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode == 4'h3) |-> (o_direct_output_enable && o_source_enable_flag
        && !o_diode_test_flag && !o_short_test_flag))
        else $error("wideband mode flags wrong");
    a_cap_flags: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode[3:1] == 3'h5) |-> (o_charge_timing_mode
        && o_source_enable_flag && !o_short_test_flag
        && !o_direct_output_enable))
        else $error("capacitance mode flags wrong");
    a_ladder_mid: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode[3:2] == 2'h0) |-> (o_sw_10k_field == {1'b0, {2{i_range[2]}}}
        && o_sw_100k_field == {1'b0, {2{i_range[1]}}}
        && o_sw_10m_field == {1'b0, |i_range}))
        else $error("divider mid fields wrong");
    a_ladder_par: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_mode[3:2] == 2'h2 && i_mode[0]) |-> (o_sw_10m_field
        == {2{~|i_range}} && o_sw_1k_field == {3{i_range[3]}}
        && o_sw_1m_field == {3{i_range[0]}}))
        else $error("parallel ladder field wrong");
    a_ref_level: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        o_source_enable_flag |-> o_ref_set
        == (i_timebase_divide ? MFD_REF_HIGH : MFD_REF_LOW))
        else $error("reference set choice wrong");
    a_ohm_fixed: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (!o_charge_timing_mode && i_ohm_source_select != 2'h1)
        |-> o_ohm_source_out == (i_ohm_source_select == 2'h0 ? MFD_SRC_HIZ
        : i_ohm_source_select == 2'h2 ? MFD_SRC_REF : MFD_SRC_VDD))
        else $error("ohm fixed source wrong");
    a_charge_level: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        o_charge_timing_mode |-> o_charge_level_high == i_timebase_divide)
        else $error("charge level choice wrong");
    a_pair_follow: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        o_charge_timing_mode |-> o_cmp_pair_second == i_charge_set_select)
        else $error("comparator pair choice wrong");
endmodule // mfd_top

// ---- design/mfd_pkg.sv ----
// Package for the meter function decoder: codes, widths and selects
package mfd_pkg;
    localparam int MODE_W = 4;
    localparam int RANGE_W = 4;
    localparam int LADDER_W = 3;
    localparam int TENM_W = 2;
    localparam logic [3:0] MODE_DC = 4'h0;
    localparam logic [3:0] MODE_DIODE = 4'h1;
    localparam logic [3:0] MODE_HBW_AC = 4'h3;
    localparam logic [2:0] MODE_OHM_PFX = 3'h4;
    localparam logic [2:0] MODE_CAP_PFX = 3'h5;
    localparam logic [1:0] MODE_DIV_PFX = 2'h0;
    localparam logic [1:0] MODE_LADDER_PFX = 2'h2;
    localparam int MODE_PARALLEL_BIT = 0;
    localparam logic [3:0] RANGE_RESET = 4'h0;
    localparam logic [3:0] MODE_RESET = 4'h0;

    // Ohm supply source encodings driven to the analog mux
    typedef enum logic [2:0] {
        MFD_SRC_HIZ = 3'h0,
        MFD_SRC_AUX5 = 3'h1,
        MFD_SRC_REF = 3'h2,
        MFD_SRC_VDD = 3'h3,
        MFD_SRC_AGND = 3'h4
    } mfd_src_t;

    // Fixed reference generator level set
    typedef enum logic [1:0] {
        MFD_REF_OFF = 2'h0,
        MFD_REF_LOW = 2'h1,
        MFD_REF_HIGH = 2'h2
    } mfd_ref_t;

    typedef struct packed {
        logic [3:0] mode;
        logic [3:0] range;
    } mfd_state_t;
endpackage : mfd_pkg

// ---- design/mfd_if.sv ----
// Interface carrying the decoded mode flags between the decoder modules
interface mfd_if;
    logic diode_test_flag;
    logic source_enable_flag;
    logic short_test_flag;
    logic charge_timing_mode;
    logic direct_output_enable;
    modport producer(
        output diode_test_flag, source_enable_flag, short_test_flag,
        output charge_timing_mode, direct_output_enable
    );
    modport consumer(
        input diode_test_flag, source_enable_flag, short_test_flag,
        input charge_timing_mode, direct_output_enable
    );
endinterface : mfd_if

// ---- design/mfd_mode_dec.sv ----
// Mode field decoder producing the five mode flags
module mfd_mode_dec
    import mfd_pkg::*;
(
    input wire logic [3:0] i_mode,
    mfd_if.producer o_flags
);
    always_comb begin
        o_flags.diode_test_flag = 1'b0;
        o_flags.source_enable_flag = 1'b0;
        o_flags.short_test_flag = 1'b0;
        o_flags.charge_timing_mode = 1'b0;
        o_flags.direct_output_enable = 1'b0;
        // Unlisted codes fall through with every flag clear
        if (i_mode == MODE_DIODE) begin
            o_flags.diode_test_flag = 1'b1;
        end else if (i_mode == MODE_HBW_AC) begin
            o_flags.source_enable_flag = 1'b1;
            o_flags.direct_output_enable = 1'b1;
        end else if (i_mode[3:1] == MODE_OHM_PFX) begin
            o_flags.source_enable_flag = 1'b1;
            o_flags.short_test_flag = 1'b1;
        end else if (i_mode[3:1] == MODE_CAP_PFX) begin
            o_flags.source_enable_flag = 1'b1;
            o_flags.charge_timing_mode = 1'b1;
        end
    end
endmodule // mfd_mode_dec

// ---- testbench/mfd_top_bench.sv ----
// Self-checking bench for the meter function decoder
module mfd_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import mfd_pkg::*;
    logic clk, rst, clk_en, tb, tog, css;
    logic [3:0] mode, range;
    logic [1:0] sel;
    logic dio, src, sht, chg, dir, pe, pf, lvl, pair;
    logic [2:0] f1k, f10k, f100k, f1m;
    logic [1:0] f10m;
    logic [3:0] seen;
    mfd_ref_t refs;
    mfd_src_t ohm;
    int fail_count, num_checks, cycles;

    mfd_top uut (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(clk_en),
        .i_mode(mode), .i_range(range), .i_timebase_divide(tb),
        .i_ohm_source_select(sel), .i_charge_toggle(tog),
        .i_charge_set_select(css), .o_diode_test_flag(dio),
        .o_source_enable_flag(src), .o_short_test_flag(sht),
        .o_charge_timing_mode(chg), .o_direct_output_enable(dir),
        .o_sw_1k_field(f1k), .o_sw_10k_field(f10k),
        .o_sw_100k_field(f100k), .o_sw_1m_field(f1m),
        .o_sw_10m_field(f10m), .o_path_10m_e(pe), .o_path_10m_f(pf),
        .o_ref_set(refs), .o_ohm_source_out(ohm),
        .o_charge_level_high(lvl), .o_cmp_pair_second(pair),
        .o_mode_seen(seen));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Flags packed as diode, source, short, charge, direct
    function automatic logic [4:0] exp_flags(input logic [3:0] m);
        casez (m)
            4'h1: return 5'h10;
            4'h3: return 5'h09;
            4'b100?: return 5'h0c;
            4'b101?: return 5'h0a;
            default: return 5'h00;
        endcase
    endfunction

    function automatic logic [13:0] exp_lad(input logic [3:0] m,
                                            input logic [3:0] r);
        logic e;
        e = |r;
        if (m[3:2] == 2'h0)
            return {1'b0, {2{r[3]}}, 1'b0, {2{r[2]}}, 1'b0, {2{r[1]}},
                    1'b0, {2{r[0]}}, 1'b0, e};
        if (m[3:2] == 2'h2)
            return {{3{r[3]}}, {3{r[2]}}, {3{r[1]}}, {3{r[0]}}, ~e,
                    m[0] ? ~e : 1'b1};
        return 14'h0000;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic drive(input logic [3:0] m, input logic [3:0] r,
                         input logic [4:0] c);
        @(posedge clk);
        #10;
        mode = m;
        range = r;
        {tb, sel, tog, css} = c;
        // Decode is combinational, so look once it has settled
        #20;
    endtask

    task automatic test_flags();
        logic [15:0] e;
        logic [15:0] g;
        for (int m = 0; m < 16; m++) begin
            drive(4'(m), 4'h0, 5'h00);
            e = 16'(exp_flags(4'(m)));
            g = 16'({dio, src, sht, chg, dir});
            chk("flags", e, g);
        end
        $display("test_flags done");
    endtask

    task automatic test_ladder();
        logic [15:0] e;
        logic [15:0] g;
        for (int m = 0; m < 16; m++) begin
            for (int r = 0; r < 16; r++) begin
                drive(4'(m), 4'(r), 5'h00);
                e = 16'(exp_lad(4'(m), 4'(r)));
                g = 16'({f1k, f10k, f100k, f1m, f10m});
                chk("ladder", e, g);
                e = 16'({|4'(r), ~|4'(r)});
                chk("path10m", e, 16'({pe, pf}));
            end
        end
        $display("test_ladder done");
    endtask

    task automatic test_refs();
        logic [4:0] f;
        logic [15:0] e;
        for (int m = 0; m < 16; m++) begin
            for (int c = 0; c < 32; c++) begin
                drive(4'(m), 4'h1, 5'(c));
                f = exp_flags(4'(m));
                e = !f[3] ? 16'h0 : (tb ? 16'h2 : 16'h1);
                chk("ref", e, 16'(refs));
                e = f[1] ? (tog ? 16'h4 : 16'h2) : 16'(sel);
                chk("ohm", e, 16'(ohm));
                chk("level", 16'(f[1] & tb), 16'(lvl));
                chk("pair", 16'(f[1] & css), 16'(pair));
            end
        end
        $display("test_refs done");
    endtask

    task automatic test_snapshot();
        drive(4'h5, 4'h0, 5'h00);
        @(posedge clk);
        #10;
        chk("seen", 16'h5, 16'(seen));
        clk_en = 1'b0;
        drive(4'h9, 4'h0, 5'h00);
        @(posedge clk);
        #10;
        chk("seen_hold", 16'h5, 16'(seen));
        clk_en = 1'b1;
        @(posedge clk);
        #10;
        chk("seen_new", 16'h9, 16'(seen));
        rst = 1'b1;
        #5;
        chk("seen_reset", 16'h0, 16'(seen));
        @(posedge clk);
        #10;
        rst = 1'b0;
        chk("seen_after", 16'h0, 16'(seen));
        $display("test_snapshot done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // The full run needs under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            $display("Error timeout expected finish seen hang");
            close_out();
        end
    end

    initial begin
        {rst, clk_en, tb, sel, tog, css} = 7'h60;
        {mode, range} = 8'h00;
        repeat (10) @(posedge clk);
        #10;
        rst = 1'b0;
        test_flags();
        test_ladder();
        test_refs();
        test_snapshot();
        close_out();
    end
endmodule // mfd_top_bench
